// ==== rtl/dma_desc_pkg.sv ====
/*
 * Constants, descriptor field layout and state encoding for the
 * descriptor-driven DMA channel.
 * Assumes a single synchronous clock domain; used by package::name only.
 */
package dma_desc_pkg;

    // Address halves
    localparam int HALF_W = 16;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 8;

    // Byte count field and its per-descriptor ceiling
    localparam int              COUNT_W   = 13;
    localparam logic [12:0]     MAX_COUNT = 13'h1000;  // 4096 bytes

    // Descriptor link field and the reserved disable value
    localparam int              LINK_W             = 8;
    localparam logic [7:0]      LINK_DISABLE_VALUE = 8'hfe;

    // Burst size field
    localparam int              BURST_W   = 8;
    localparam logic [7:0]      BURST_MIN = 8'h01;

    // Descriptor flag positions
    localparam int FLAGS_W           = 5;
    localparam int SOURCE_INC_BIT    = 0;
    localparam int DEST_INC_BIT      = 1;
    localparam int COMPLETION_BIT    = 2;
    localparam int BYTE_SWAP_BIT     = 3;
    localparam int SWAP_QUAD_BIT     = 4;

    // Byte index masks that reverse order within a swap group
    localparam logic [12:0] SWAP_MASK_NONE = 13'h0000;
    localparam logic [12:0] SWAP_MASK_PAIR = 13'h0001;
    localparam logic [12:0] SWAP_MASK_QUAD = 13'h0003;

    // Channel sequencer, one-hot
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_LOAD   = 6'h02,
        ST_WAIT   = 6'h04,
        ST_BURST  = 6'h08,
        ST_FINISH = 6'h10,
        ST_SPARE  = 6'h20
    } chan_state_t;

endpackage

// ==== rtl/dma_channel_descriptor_engine.sv ====
/*
 * One DMA channel running chains of transfer descriptors held in a local table.
 * Assumes byte-wide read and write ports to a system fabric on the same clock,
 * one read outstanding at a time, and software that loads descriptors while
 * the channel is idle.
 */
// Summary of operation
// - A set source increment flag advances the source address by the burst after every burst.
// - A set destination increment flag advances the destination address by the burst, together with source if both.
// - A set completion pulse flag gives one pulse on done_pulse_out once the whole count is moved.
// - A link equal to the disable value turns the channel off after the current descriptor.
// - With the keep option the descriptor is reloaded from its original values, so a self link repeats forever.
// - With request-per-burst cleared only the first burst of a descriptor waits for a request.
// - A descriptor count is limited to 4096 bytes; larger values are clamped.
// - A link to another descriptor continues there, so two mutually linked descriptors alternate.
// - A CPU request starts transfers exactly like the hardware request line.
// - Full addresses join the channel's upper halves with the descriptor's lower halves.
// - Each burst moves the configured number of bytes, or the remaining count if smaller; one byte per burst when the size is zero or one.
// - The remaining count drops by the burst size after each burst and the descriptor ends at zero.
// - The swap flag reverses byte order in groups of two, or four with the quad flag.
module dma_channel_descriptor_engine #(
    parameter int NUM_DESC = 16
) (
    // Clock and reset
    input  wire logic                                  ref_clk_in,
    input  wire logic                                  rst_in,
    // Channel configuration
    input  wire logic [dma_desc_pkg::HALF_W-1:0]       cfg_src_hi_in,
    input  wire logic [dma_desc_pkg::HALF_W-1:0]       cfg_dst_hi_in,
    input  wire logic [dma_desc_pkg::BURST_W-1:0]      cfg_burst_in,
    input  wire logic                                  cfg_req_per_burst_in,
    input  wire logic                                  cfg_keep_descriptor_in,
    input  wire logic [dma_desc_pkg::LINK_W-1:0]       cfg_first_desc_in,
    input  wire logic                                  chan_enable_in,
    // Requests
    input  wire logic                                  hw_req_in,
    input  wire logic                                  cpu_req_in,
    // Descriptor table write port
    input  wire logic                                  desc_wr_in,
    input  wire logic [dma_desc_pkg::LINK_W-1:0]       desc_idx_in,
    input  wire logic [dma_desc_pkg::HALF_W-1:0]       desc_src_lo_in,
    input  wire logic [dma_desc_pkg::HALF_W-1:0]       desc_dst_lo_in,
    input  wire logic [dma_desc_pkg::COUNT_W-1:0]      desc_count_in,
    input  wire logic [dma_desc_pkg::FLAGS_W-1:0]      desc_flags_in,
    input  wire logic [dma_desc_pkg::LINK_W-1:0]       desc_next_in,
    // Read port
    output logic                                       rd_valid_out,
    output logic [dma_desc_pkg::ADDR_W-1:0]            rd_addr_out,
    input  wire logic                                  rd_ready_in,
    input  wire logic                                  rd_data_valid_in,
    input  wire logic [dma_desc_pkg::DATA_W-1:0]       rd_data_in,
    // Write port
    output logic                                       wr_valid_out,
    output logic [dma_desc_pkg::ADDR_W-1:0]            wr_addr_out,
    output logic [dma_desc_pkg::DATA_W-1:0]            wr_data_out,
    input  wire logic                                  wr_ready_in,
    // Status
    output logic                                       chan_enabled_out,
    output logic                                       done_pulse_out
);

    localparam int CW = dma_desc_pkg::COUNT_W;
    localparam int HW = dma_desc_pkg::HALF_W;

    // Descriptor table
    logic [HW-1:0]                    d_src   [NUM_DESC];
    logic [HW-1:0]                    d_dst   [NUM_DESC];
    logic [CW-1:0]                    d_cnt   [NUM_DESC];
    logic [dma_desc_pkg::FLAGS_W-1:0] d_flags [NUM_DESC];
    logic [dma_desc_pkg::LINK_W-1:0]  d_next  [NUM_DESC];

    // Working copy of the active descriptor
    dma_desc_pkg::chan_state_t        state;
    logic [dma_desc_pkg::LINK_W-1:0]  cur_idx;
    logic [HW-1:0]                    w_src;
    logic [HW-1:0]                    w_dst;
    logic [CW-1:0]                    w_cnt;
    logic [dma_desc_pkg::FLAGS_W-1:0] w_flags;
    logic [dma_desc_pkg::LINK_W-1:0]  w_next;
    logic                             first_burst;
    logic                             req_pending;

    // Burst progress
    logic [CW-1:0]                    burst_len;
    logic [CW-1:0]                    rd_i;
    logic [CW-1:0]                    push_i;
    logic [CW-1:0]                    wr_i;
    logic                             rd_busy;

    // Two-entry buffer, slot 0 is the head shown on the write port
    logic                             v1;
    logic [dma_desc_pkg::ADDR_W-1:0]  a1;
    logic [dma_desc_pkg::DATA_W-1:0]  b1;

    logic [CW-1:0]                    cfg_burst_w;
    logic [CW-1:0]                    swap_mask;
    logic [CW-1:0]                    table_cnt;
    logic                             pop;
    logic                             push;
    logic                             can_issue;
    logic                             go_burst;
    logic [dma_desc_pkg::ADDR_W-1:0]  push_addr;

    // Zero burst size would never finish, so it counts as one byte
    assign cfg_burst_w = (cfg_burst_in == '0) ? CW'(dma_desc_pkg::BURST_MIN) : CW'(cfg_burst_in);
    // Counts above the ceiling are clamped rather than rejected
    assign table_cnt = (d_cnt[cur_idx[$clog2(NUM_DESC)-1:0]] > dma_desc_pkg::MAX_COUNT) ?
                       dma_desc_pkg::MAX_COUNT : d_cnt[cur_idx[$clog2(NUM_DESC)-1:0]];
    // Reading the group back to front reverses its bytes on the way through
    assign swap_mask = !w_flags[dma_desc_pkg::BYTE_SWAP_BIT] ? dma_desc_pkg::SWAP_MASK_NONE :
                       w_flags[dma_desc_pkg::SWAP_QUAD_BIT] ? dma_desc_pkg::SWAP_MASK_QUAD :
                       dma_desc_pkg::SWAP_MASK_PAIR;
    assign pop       = wr_valid_out & wr_ready_in;
    assign push      = rd_data_valid_in & rd_busy;
    // One read in flight plus the buffer contents never exceed two slots
    assign can_issue = (state == dma_desc_pkg::ST_BURST) && !rd_valid_out && !rd_busy &&
                       (rd_i < burst_len) && !(wr_valid_out & v1);
    assign go_burst  = (state == dma_desc_pkg::ST_WAIT) &&
                       (req_pending || (!cfg_req_per_burst_in && !first_burst));
    assign push_addr = {cfg_dst_hi_in, HW'(w_dst + HW'(push_i))};

    // Enable flag: software enable wins over a disabling link in the same cycle
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            chan_enabled_out <= 1'b0;
        end else begin
            chan_enabled_out <= chan_enable_in | (chan_enabled_out &
                ~((state == dma_desc_pkg::ST_FINISH) && (w_next == dma_desc_pkg::LINK_DISABLE_VALUE)));
        end
    end

    // Request latch: a new request wins over its consumption
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            req_pending <= 1'b0;
        end else begin
            req_pending <= (chan_enabled_out & (hw_req_in | cpu_req_in)) |
                           (req_pending & ~go_burst & chan_enabled_out);
        end
    end

    // Descriptor table: software writes take priority over write-back
    always_ff @(posedge ref_clk_in) begin
        if (desc_wr_in) begin
            d_src[desc_idx_in[$clog2(NUM_DESC)-1:0]]   <= desc_src_lo_in;
            d_dst[desc_idx_in[$clog2(NUM_DESC)-1:0]]   <= desc_dst_lo_in;
            d_cnt[desc_idx_in[$clog2(NUM_DESC)-1:0]]   <= desc_count_in;
            d_flags[desc_idx_in[$clog2(NUM_DESC)-1:0]] <= desc_flags_in;
            d_next[desc_idx_in[$clog2(NUM_DESC)-1:0]]  <= desc_next_in;
        end else if ((state == dma_desc_pkg::ST_FINISH) && !cfg_keep_descriptor_in) begin
            d_src[cur_idx[$clog2(NUM_DESC)-1:0]] <= w_src;
            d_dst[cur_idx[$clog2(NUM_DESC)-1:0]] <= w_dst;
            d_cnt[cur_idx[$clog2(NUM_DESC)-1:0]] <= w_cnt;
        end
    end

    // Channel sequencer and working descriptor
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state          <= dma_desc_pkg::ST_IDLE;
            cur_idx        <= '0;
            w_src          <= '0;
            w_dst          <= '0;
            w_cnt          <= '0;
            w_flags        <= '0;
            w_next         <= '0;
            first_burst    <= 1'b0;
            burst_len      <= '0;
            done_pulse_out <= 1'b0;
        end else begin
            done_pulse_out <= 1'b0;
            case (state)
                dma_desc_pkg::ST_IDLE: begin
                    if (chan_enabled_out) begin
                        cur_idx <= cfg_first_desc_in;
                        state   <= dma_desc_pkg::ST_LOAD;
                    end
                end
                dma_desc_pkg::ST_LOAD: begin
                    // Reloading from the table restores originals when kept
                    w_src       <= d_src[cur_idx[$clog2(NUM_DESC)-1:0]];
                    w_dst       <= d_dst[cur_idx[$clog2(NUM_DESC)-1:0]];
                    w_cnt       <= table_cnt;
                    w_flags     <= d_flags[cur_idx[$clog2(NUM_DESC)-1:0]];
                    w_next      <= d_next[cur_idx[$clog2(NUM_DESC)-1:0]];
                    first_burst <= 1'b1;
                    state       <= (table_cnt == '0) ? dma_desc_pkg::ST_FINISH : dma_desc_pkg::ST_WAIT;
                end
                dma_desc_pkg::ST_WAIT: begin
                    if (!chan_enabled_out) begin
                        state <= dma_desc_pkg::ST_IDLE;
                    end else if (go_burst) begin
                        burst_len   <= (cfg_burst_w < w_cnt) ? cfg_burst_w : w_cnt;
                        first_burst <= 1'b0;
                        state       <= dma_desc_pkg::ST_BURST;
                    end
                end
                dma_desc_pkg::ST_BURST: begin
                    if (wr_i == burst_len) begin
                        w_cnt <= w_cnt - burst_len;
                        if (w_flags[dma_desc_pkg::SOURCE_INC_BIT]) begin
                            w_src <= w_src + HW'(burst_len);
                        end
                        if (w_flags[dma_desc_pkg::DEST_INC_BIT]) begin
                            w_dst <= w_dst + HW'(burst_len);
                        end
                        state <= (w_cnt == burst_len) ? dma_desc_pkg::ST_FINISH : dma_desc_pkg::ST_WAIT;
                    end
                end
                dma_desc_pkg::ST_FINISH: begin
                    done_pulse_out <= w_flags[dma_desc_pkg::COMPLETION_BIT];
                    if (w_next == dma_desc_pkg::LINK_DISABLE_VALUE) begin
                        state <= dma_desc_pkg::ST_IDLE;
                    end else begin
                        cur_idx <= w_next;
                        state   <= dma_desc_pkg::ST_LOAD;
                    end
                end
                default: begin
                    state <= dma_desc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Read issue, one byte at a time with its swap-adjusted offset
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rd_valid_out <= 1'b0;
            rd_addr_out  <= '0;
            rd_busy      <= 1'b0;
            rd_i         <= '0;
        end else begin
            if (state != dma_desc_pkg::ST_BURST) begin
                rd_i <= '0;
            end else if (can_issue) begin
                rd_valid_out <= 1'b1;
                rd_addr_out  <= {cfg_src_hi_in, HW'(w_src + HW'(rd_i ^ swap_mask))};
                rd_busy      <= 1'b1;
                rd_i         <= rd_i + CW'(1);
            end
            if (rd_valid_out && rd_ready_in) begin
                rd_valid_out <= 1'b0;
            end
            if (push) begin
                rd_busy <= 1'b0;
            end
        end
    end

    // Push and drain counts within the burst
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || (state != dma_desc_pkg::ST_BURST)) begin
            push_i <= '0;
            wr_i   <= '0;
        end else begin
            if (push) begin
                push_i <= push_i + CW'(1);
            end
            if (pop) begin
                wr_i <= wr_i + CW'(1);
            end
        end
    end

    // Two-entry buffer; a stalled write port holds the reads back
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wr_valid_out <= 1'b0;
            wr_addr_out  <= '0;
            wr_data_out  <= '0;
            v1           <= 1'b0;
            a1           <= '0;
            b1           <= '0;
        end else if (pop && v1) begin
            wr_addr_out  <= a1;
            wr_data_out  <= b1;
            v1           <= push;
            if (push) begin
                a1 <= push_addr;
                b1 <= rd_data_in;
            end
        end else if (pop || (push && !wr_valid_out)) begin
            wr_valid_out <= push;
            if (push) begin
                wr_addr_out <= push_addr;
                wr_data_out <= rd_data_in;
            end
        end else if (push) begin
            v1 <= 1'b1;
            a1 <= push_addr;
            b1 <= rd_data_in;
        end
    end

endmodule // dma_channel_descriptor_engine

// ==== bench/dma_engine_checker_assertions.sv ====
/* Port checker for the descriptor DMA channel.
   Assumes one clock domain; bound to every channel instance. */
module dma_engine_checker (
    // Clock and reset
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    // Control
    input wire logic [15:0] cfg_src_hi_in,
    input wire logic [15:0] cfg_dst_hi_in,
    input wire logic        chan_enable_in,
    // Fabric ports
    input wire logic        rd_valid_out,
    input wire logic [31:0] rd_addr_out,
    input wire logic        rd_ready_in,
    input wire logic        rd_data_valid_in,
    input wire logic        wr_valid_out,
    input wire logic [31:0] wr_addr_out,
    input wire logic [7:0]  wr_data_out,
    input wire logic        wr_ready_in,
    // Status
    input wire logic        chan_enabled_out,
    input wire logic        done_pulse_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic in_flight;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    // One accepted read stays open until its data returns
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            in_flight <= 1'b0;
        end else if (rd_valid_out && rd_ready_in) begin
            in_flight <= 1'b1;
        end else if (rd_data_valid_in) begin
            in_flight <= 1'b0;
        end
    end

    AST_RD_HOLD: assert property (rd_valid_out && !rd_ready_in |=> rd_valid_out && $stable(rd_addr_out))
        else $error("read request changed before accept");
    AST_WR_HOLD: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable({wr_addr_out, wr_data_out}))
        else $error("write request changed before accept");
    AST_ONE_READ: assert property (in_flight |-> !rd_valid_out)
        else $error("second read while one is open");
    AST_SRC_HI: assert property (rd_valid_out |-> rd_addr_out[31:16] == cfg_src_hi_in)
        else $error("read address upper half wrong");
    AST_DST_HI: assert property (wr_valid_out |-> wr_addr_out[31:16] == cfg_dst_hi_in)
        else $error("write address upper half wrong");
    AST_QUIET_OFF: assert property (!chan_enabled_out |-> !rd_valid_out && !wr_valid_out)
        else $error("traffic while disabled");
    AST_ON_CAUSE: assert property ($rose(chan_enabled_out) |-> $past(chan_enable_in))
        else $error("enabled without enable input");
    AST_DONE_ONE: assert property (done_pulse_out |=> !done_pulse_out)
        else $error("completion pulse longer than one cycle");

    COV_DONE: cover property (done_pulse_out);
    COV_RD_STALL: cover property (rd_valid_out && !rd_ready_in);
    COV_WR_STALL: cover property (wr_valid_out && !wr_ready_in);
endmodule // dma_engine_checker

bind dma_channel_descriptor_engine dma_engine_checker i_dma_engine_checker (.*);

// ==== bench/fabric_model.sv ====
/* Byte-wide fabric behind the channel: reads return a pattern of the address, writes are logged.
   Assumes the channel holds each request until ready is seen. */
module fabric_model (
    // Clock, reset and pacing
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        slow_in,
    // Read port
    input  wire logic        rd_valid_in,
    input  wire logic [31:0] rd_addr_in,
    output logic             rd_ready_out,
    output logic             rd_data_valid_out,
    output logic [7:0]       rd_data_out,
    // Write port
    input  wire logic        wr_valid_in,
    input  wire logic [31:0] wr_addr_in,
    input  wire logic [7:0]  wr_data_in,
    output logic             wr_ready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0]  tick;
    logic [31:0] wa[$];
    logic [7:0]  wd[$];

    // Slow mode grants once in four cycles; idle data toggles so stale bytes never look valid
    always @(posedge clk_in) begin
        if (rst_in) begin
            {tick, rd_ready_out, rd_data_valid_out, rd_data_out, wr_ready_out} <= 13'h0;
        end else begin
            tick <= tick + 2'h1;
            rd_ready_out <= rd_valid_in && !rd_ready_out && (!slow_in || tick == 2'h0);
            rd_data_valid_out <= rd_valid_in && rd_ready_out;
            rd_data_out <= (rd_valid_in && rd_ready_out) ? (rd_addr_in[7:0] ^ rd_addr_in[23:16]) : ~rd_data_out;
            wr_ready_out <= !slow_in || tick == 2'h2;
            if (wr_valid_in && wr_ready_out) begin
                wa.push_back(wr_addr_in);
                wd.push_back(wr_data_in);
            end
        end
    end
endmodule // fabric_model

// ==== bench/tb.sv ====
/* Self-checking bench for the descriptor DMA channel.
   Assumes the fabric model answers every read it accepts. */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_in, rst_in, cfg_req_per_burst_in, cfg_keep_descriptor_in, chan_enable_in, slow;
    logic        hw_req_in, cpu_req_in, desc_wr_in, rd_valid_out, rd_ready_in, rd_data_valid_in;
    logic        wr_valid_out, wr_ready_in, chan_enabled_out, done_pulse_out;
    logic [15:0] cfg_src_hi_in, cfg_dst_hi_in, desc_src_lo_in, desc_dst_lo_in;
    logic [7:0]  cfg_burst_in, cfg_first_desc_in, desc_idx_in, desc_next_in, rd_data_in, wr_data_out, ed[$];
    logic [31:0] rd_addr_out, wr_addr_out, ea[$];
    logic [12:0] desc_count_in;
    logic [4:0]  desc_flags_in;
    int          errors, checks, cycles, dones;

    dma_channel_descriptor_engine #(.NUM_DESC(16)) i_dma_channel_descriptor_engine (.ref_clk_in, .rst_in,
        .cfg_src_hi_in, .cfg_dst_hi_in, .cfg_burst_in, .cfg_req_per_burst_in, .cfg_keep_descriptor_in,
        .cfg_first_desc_in, .chan_enable_in, .hw_req_in, .cpu_req_in, .desc_wr_in, .desc_idx_in,
        .desc_src_lo_in, .desc_dst_lo_in, .desc_count_in, .desc_flags_in, .desc_next_in, .rd_valid_out,
        .rd_addr_out, .rd_ready_in, .rd_data_valid_in, .rd_data_in, .wr_valid_out, .wr_addr_out,
        .wr_data_out, .wr_ready_in, .chan_enabled_out, .done_pulse_out);
    fabric_model i_fabric_model (.clk_in(ref_clk_in), .rst_in, .slow_in(slow), .rd_valid_in(rd_valid_out),
        .rd_addr_in(rd_addr_out), .rd_ready_out(rd_ready_in), .rd_data_valid_out(rd_data_valid_in),
        .rd_data_out(rd_data_in), .wr_valid_in(wr_valid_out), .wr_addr_in(wr_addr_out),
        .wr_data_in(wr_data_out), .wr_ready_out(wr_ready_in));

    // Clock
    initial ref_clk_in = 1'b0;
    always #5 ref_clk_in = ~ref_clk_in;

    // Pulse tally and hang ceiling, well above the longest test
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (done_pulse_out === 1'b1) dones <= dones + 1;
        if (cycles == 60000) begin
            errors++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One table write, one entry every two cycles
    task automatic put(input logic [7:0] idx, input logic [15:0] src, dst, input logic [12:0] cnt,
                       input logic [4:0] fl, input logic [7:0] nxt);
        @(negedge ref_clk_in);
        {desc_wr_in, desc_idx_in, desc_src_lo_in, desc_dst_lo_in, desc_count_in, desc_flags_in, desc_next_in} =
            {1'b1, idx, src, dst, cnt, fl, nxt};
        @(negedge ref_clk_in);
        desc_wr_in = 1'b0;
        dones = 0;
    endtask

    // Enable, then let the idle and load states pass before any request
    task automatic start(input logic [7:0] first, burst, input logic rpb, keep);
        @(negedge ref_clk_in);
        {cfg_first_desc_in, cfg_burst_in, cfg_req_per_burst_in, cfg_keep_descriptor_in, chan_enable_in} =
            {first, burst, rpb, keep, 1'b1};
        @(negedge ref_clk_in);
        chan_enable_in = 1'b0;
        repeat (3) @(negedge ref_clk_in);
        chk("enabled", 1, chan_enabled_out);
    endtask

    // Request pulse, then bounded wait until the log reaches the target
    task automatic kick(input logic cpu, input int target);
        int n;
        @(negedge ref_clk_in);
        {cpu_req_in, hw_req_in} = {cpu, !cpu};
        @(negedge ref_clk_in);
        {cpu_req_in, hw_req_in} = 2'b00;
        n = 0;
        while (i_fabric_model.wa.size() < target && n < 20000) begin
            @(negedge ref_clk_in);
            n++;
        end
        chk("write count", target, i_fabric_model.wa.size());
    endtask

    task automatic wait_off();
        int n;
        n = 0;
        while (chan_enabled_out !== 1'b0 && n < 100) begin
            @(negedge ref_clk_in);
            n++;
        end
        repeat (2) @(negedge ref_clk_in);
        chk("enabled after last", 0, chan_enabled_out);
    endtask

    // Expected writes; swap reads byte j^mask of each burst
    task automatic expect_desc(input logic [15:0] src, dst, input int cnt, input logic [4:0] fl, input int burst);
        int          n;
        logic [31:0] sa;
        int          m;
        m = fl[3] ? (fl[4] ? 3 : 1) : 0;
        for (int b = 0; b < cnt; b += burst) begin
            n = (cnt - b < burst) ? cnt - b : burst;
            for (int j = 0; j < n; j++) begin
                sa = {cfg_src_hi_in, 16'(src + (fl[0] ? b : 0) + (j ^ m))};
                ea.push_back({cfg_dst_hi_in, 16'(dst + (fl[1] ? b : 0) + j)});
                ed.push_back(sa[7:0] ^ sa[23:16]);
            end
        end
    endtask

    task automatic check_writes(input string name);
        chk("write total", ea.size(), i_fabric_model.wa.size());
        foreach (ea[i]) begin
            if (i < i_fabric_model.wa.size()) begin
                chk("write address", ea[i], i_fabric_model.wa[i]);
                chk("write data", 32'(ed[i]), 32'(i_fabric_model.wd[i]));
            end
        end
        ea.delete();
        ed.delete();
        i_fabric_model.wa.delete();
        i_fabric_model.wd.delete();
        $display("test %s done", name);
    endtask

    initial begin
        {rst_in, slow, chan_enable_in, hw_req_in, cpu_req_in, desc_wr_in, errors, checks, cycles} = 102'h1 << 101;
        {cfg_src_hi_in, cfg_dst_hi_in} = 32'h0012_0034;
        {cfg_burst_in, cfg_first_desc_in, cfg_req_per_burst_in, cfg_keep_descriptor_in} = 18'h0;
        {desc_idx_in, desc_src_lo_in, desc_dst_lo_in, desc_count_in, desc_flags_in, desc_next_in} = 66'h0;
        repeat (5) @(negedge ref_clk_in);
        rst_in = 1'b0;
        // Requests while disabled, then one byte per requested burst
        put(8'h00, 16'h0100, 16'h0200, 13'h0004, 5'h07, 8'hfe);
        kick(1'b0, 0);
        kick(1'b1, 0);
        start(8'h00, 8'h01, 1'b1, 1'b0);
        // A request latched while disabled would start a burst here
        repeat (8) @(negedge ref_clk_in);
        chk("write count", 0, i_fabric_model.wa.size());
        expect_desc(16'h0100, 16'h0200, 4, 5'h07, 1);
        for (int i = 1; i <= 4; i++) kick(i[0], i);
        wait_off();
        check_writes("single byte bursts");
        chk("done pulses", 1, dones);
        // Quad swap, one request for the whole descriptor, stalling fabric
        slow = 1'b1;
        put(8'h05, 16'h0300, 16'h0400, 13'h0008, 5'h1d, 8'hfe);
        start(8'h05, 8'h04, 1'b0, 1'b0);
        expect_desc(16'h0300, 16'h0400, 8, 5'h1d, 4);
        kick(1'b1, 8);
        wait_off();
        check_writes("quad swap");
        // Chain with pair swap and a short last burst
        slow = 1'b0;
        put(8'h01, 16'h0500, 16'h0600, 13'h0004, 5'h0b, 8'h02);
        put(8'h02, 16'h0700, 16'h0800, 13'h0005, 5'h07, 8'hfe);
        start(8'h01, 8'h02, 1'b0, 1'b0);
        expect_desc(16'h0500, 16'h0600, 4, 5'h0b, 2);
        expect_desc(16'h0700, 16'h0800, 5, 5'h07, 2);
        kick(1'b0, 4);
        kick(1'b0, 9);
        wait_off();
        check_writes("chain");
        chk("done pulses", 1, dones);
        // Kept descriptor linked to itself repeats from its original values
        put(8'h03, 16'h0900, 16'h0a00, 13'h0002, 5'h05, 8'h03);
        start(8'h03, 8'h01, 1'b1, 1'b1);
        for (int i = 0; i < 2; i++) expect_desc(16'h0900, 16'h0a00, 2, 5'h05, 1);
        for (int i = 1; i <= 4; i++) kick(1'b0, i);
        repeat (6) @(negedge ref_clk_in);
        check_writes("kept self loop");
        chk("done pulses", 2, dones);
        chk("still enabled", 1, chan_enabled_out);
        rst_in = 1'b1;
        @(negedge ref_clk_in);
        rst_in = 1'b0;
        chk("enabled after reset", 0, chan_enabled_out);
        // Oversized count stops at the ceiling
        put(8'h08, 16'h1000, 16'h2000, 13'h1fff, 5'h03, 8'hfe);
        start(8'h08, 8'hff, 1'b0, 1'b0);
        expect_desc(16'h1000, 16'h2000, 4096, 5'h03, 255);
        kick(1'b1, 4096);
        wait_off();
        check_writes("count ceiling");
        conclude();
    end
endmodule // tb
